// ==== design/tle_channel.sv ====
// Overview of operation
// - Signal loss asserts after 100 zeros (DS1) or 255 zeros (CEPT).
// - Loss clears at 12.5% ones; zero run limit 15 strict, else 99.
// - Rail select low: single NRZ line; high: positive and negative lines.
// - Transmitter makes AMI, with optional B8ZS (DS1) or HDB3 (CEPT).
// - Zero gives no pulse; positive mark pulses the ring output.
// - Input to driver latency about 5 to 10 bit periods, per substitution bit.
// - Jitter attenuator in transmit path adds further latency.
// - Internal timer sets pulse width, independent of clock duty cycle.
// - Three-bit equalizer field selects equalization and line rate.
// - Codes 000 to 100 select DS1 cable ranges up to 3.0 dB.
// - Code 101 CEPT 75 ohm opt 2; 110 CEPT 120/75 opt 1; 111 unused.
// - Substitution only in single-rail mode with substitution bit set.
// - DS1 ones density evaluated over 100 contiguous positions.
// - Loss-standard bit picks DS1 clearing criterion; CEPT unaffected.
module tle_channel (
  input wire logic i_mclk, // 100 MHz clock
  input wire logic i_reset, // Sync reset, active high
  input wire logic i_system_transmit_clock, // Framer bit clock pin
  input wire logic i_tx_pos_data, // NRZ data, or positive rail
  input wire logic i_tx_neg_data, // Negative rail (dual-rail)
  input wire logic i_rail_select, // 1 = dual-rail
  input wire logic i_zero_subst, // Substitution enable
  input wire logic i_tx_jitter_atten_select, // Extra transmit delay
  input wire logic i_eq_code_bit_a, // Equalizer code msb
  input wire logic i_eq_code_bit_b, // Equalizer code mid
  input wire logic i_eq_code_bit_c, // Equalizer code lsb
  input wire logic i_loss_standard_select, // 1 = strict DS1 criterion
  input wire logic i_rx_clk_en, // Receive bit strobe, same domain
  input wire logic i_rx_mark, // Received pulse in this bit
  output logic o_line_tip_output, // Negative pulse drive
  output logic o_line_ring_output, // Positive pulse drive
  output logic o_tx_fifo_ready, // Transmit buffer has space
  output logic o_cept_mode, // Line rate is CEPT
  output logic o_eq_code_illegal, // Unused equalizer code
  output logic o_digital_signal_loss // Receive loss flag
);
  // ==========================================
  // Pin synchronisers and bit strobe
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic clk_d_reg;
  logic bit_en;
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      s1_reg <= '0;
      s2_reg <= '0;
      clk_d_reg <= 1'b0;
    end else begin
      s1_reg <= {i_system_transmit_clock, i_tx_neg_data, i_tx_pos_data};
      s2_reg <= s1_reg;
      clk_d_reg <= s2_reg[2];
    end
  end
  assign bit_en = s2_reg[2] && !clk_d_reg;

  logic [2:0] eq_code;
  logic cept;
  logic subst_on;
  assign eq_code = {i_eq_code_bit_a, i_eq_code_bit_b, i_eq_code_bit_c};
  assign cept = (eq_code == tle_pkg::EQ_CEPT_OPT2) || (eq_code == tle_pkg::EQ_CEPT_120);
  assign subst_on = i_zero_subst && !i_rail_select;

  // ==========================================
  // Input buffer: decouples framer strobe from encoder pacing
  logic [1:0] sym_in;
  logic in_valid;
  logic f_valid;
  logic [1:0] f_data;
  logic pipe_adv;
  logic fifo_rdy;
  // Single-rail: mark on pos line; dual-rail: each rail its own mark
  assign sym_in = i_rail_select ? {s2_reg[1], s2_reg[0]} : {1'b0, s2_reg[0]};
  assign in_valid = bit_en;
  tle_fifo #(.WIDTH(2), .DEPTH(32)) u_fifo (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_valid(in_valid),
    .o_ready(fifo_rdy),
    .i_data(sym_in),
    .o_valid(f_valid),
    .i_ready(pipe_adv),
    .o_data(f_data)
  );
  // Encoder advances one bit per strobe once buffer holds the latency depth
  logic [5:0] fill_reg;
  logic primed_reg;
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      fill_reg <= '0;
      primed_reg <= 1'b0;
    end else if (bit_en && !primed_reg) begin
      fill_reg <= fill_reg + 6'd1;
      if (fill_reg + 6'd1 >= 6'(i_tx_jitter_atten_select ? tle_pkg::JA_EXTRA_DELAY : 0)) begin
        primed_reg <= 1'b1;
      end
    end
  end
  assign pipe_adv = bit_en && primed_reg && f_valid;
  // Port from a flop; one cycle late, the framer paces far slower
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_tx_fifo_ready <= 1'b1;
    end else begin
      o_tx_fifo_ready <= fifo_rdy;
    end
  end

  // ==========================================
  // Zero-substitution encoder: 8-bit lookahead line
  logic [7:0] dly_reg;
  logic [7:0] neg_reg;
  logic last_pol_reg;
  logic odd_marks_reg;
  logic [7:0] dly_next;
  logic [7:0] neg_next;
  logic odd_next;
  logic mark_out;
  logic pol_out;
  logic [1:0] sym_out_reg;
  // Single-rail: neg bit marks a violation, i.e. repeat the last polarity.
  // Relative polarity stays right while earlier marks still sit in the line.
  always_comb begin
    dly_next = {dly_reg[6:0], f_data[0]};
    neg_next = {neg_reg[6:0], f_data[1]};
    odd_next = odd_marks_reg ^ f_data[0];
    if (subst_on && !cept && dly_next == 8'h00) begin
      // B8ZS 000VB0VB
      dly_next = 8'b0001_1011;
      neg_next = 8'b0001_0010;
    end else if (subst_on && cept && dly_next[3:0] == 4'h0) begin
      // HDB3: 000V after odd marks since last V, else B00V
      dly_next[3:0] = odd_marks_reg ? 4'b0001 : 4'b1001;
      neg_next[3:0] = 4'b0001;
      odd_next = 1'b0;
    end
  end
  assign mark_out = subst_on ? dly_reg[7] : dly_reg[2];
  assign pol_out = (subst_on && neg_reg[7]) ? last_pol_reg : !last_pol_reg;
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      dly_reg <= tle_pkg::RST_ZERO;
      neg_reg <= tle_pkg::RST_ZERO;
      last_pol_reg <= 1'b0;
      odd_marks_reg <= 1'b0;
      sym_out_reg <= '0;
    end else if (pipe_adv) begin
      dly_reg <= dly_next;
      neg_reg <= neg_next;
      odd_marks_reg <= odd_next;
      // Dual-rail: pass through, 3-bit delay
      sym_out_reg <= i_rail_select ? {neg_reg[2], dly_reg[2]} : 2'b00;
      if (!i_rail_select && mark_out) begin
        last_pol_reg <= pol_out;
        sym_out_reg <= pol_out ? 2'b10 : 2'b01;
      end
    end
  end

  // ==========================================
  // Pulse-width timer: fixed width from fast clock
  logic [5:0] pw_reg;
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pw_reg <= '0;
      o_line_ring_output <= 1'b0;
      o_line_tip_output <= 1'b0;
    end else if (pipe_adv && sym_out_reg != 2'b00) begin
      pw_reg <= 6'(cept ? tle_pkg::CEPT_PW_CYC : tle_pkg::DS1_PW_CYC);
      o_line_ring_output <= sym_out_reg[0];
      o_line_tip_output <= sym_out_reg[1];
    end else if (pw_reg > 6'd1) begin
      pw_reg <= pw_reg - 6'd1;
    end else begin
      pw_reg <= '0;
      o_line_ring_output <= 1'b0;
      o_line_tip_output <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_cept_mode <= 1'b0;
      o_eq_code_illegal <= 1'b0;
    end else begin
      o_cept_mode <= cept;
      o_eq_code_illegal <= eq_code == tle_pkg::EQ_UNUSED;
    end
  end

  // ==========================================
  // Digital signal-loss monitor
  logic [7:0] zrun_reg;
  logic [7:0] win_reg;
  logic [7:0] ones_reg;
  logic run_bad_reg;
  logic [7:0] los_lim;
  logic [7:0] win_len;
  logic [7:0] ones_min;
  logic [7:0] zmax;
  assign los_lim = 8'(cept ? tle_pkg::CEPT_LOS_ZEROS : tle_pkg::DS1_LOS_ZEROS);
  assign win_len = 8'(cept ? tle_pkg::CEPT_WINDOW : tle_pkg::DS1_WINDOW);
  assign ones_min = 8'(cept ? tle_pkg::CEPT_MIN_ONES : tle_pkg::DS1_MIN_ONES);
  assign zmax = 8'((!cept && i_loss_standard_select) ? tle_pkg::STRICT_MAX_ZRUN
                                                      : tle_pkg::LOOSE_MAX_ZRUN);
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      zrun_reg <= '0;
      win_reg <= '0;
      ones_reg <= '0;
      run_bad_reg <= 1'b0;
      o_digital_signal_loss <= 1'b0;
    end else if (i_rx_clk_en) begin
      zrun_reg <= i_rx_mark ? 8'h00 : (zrun_reg == 8'hff ? zrun_reg : zrun_reg + 8'h01);
      if (!i_rx_mark && zrun_reg + 8'h01 >= los_lim) begin
        o_digital_signal_loss <= 1'b1;
      end
      if (win_reg + 8'h01 >= win_len) begin
        // Window closes: clear when density met and no long run inside
        if (o_digital_signal_loss && !run_bad_reg &&
            ones_reg + 8'(i_rx_mark) >= ones_min &&
            (i_rx_mark || zrun_reg < zmax)) begin
          o_digital_signal_loss <= 1'b0;
        end
        win_reg <= '0;
        ones_reg <= '0;
        run_bad_reg <= 1'b0;
      end else begin
        win_reg <= win_reg + 8'h01;
        ones_reg <= ones_reg + 8'(i_rx_mark);
        if (!i_rx_mark && zrun_reg >= zmax) begin
          run_bad_reg <= 1'b1;
        end
      end
    end
  end
endmodule // tle_channel

// ==== design/tle_pkg.sv ====
package tle_pkg;
  // ==========================================
  // Control bit positions (per-channel control word)
  localparam int RAIL_SEL_BIT = 4;
  localparam int ZSUB_BIT = 3;
  localparam int EQ_LSB = 5;
  localparam int LOSS_STD_BIT = 2;
  // ==========================================
  // Equalizer codes
  localparam logic [2:0] EQ_DS1_MAX = 3'h4;
  localparam logic [2:0] EQ_CEPT_OPT2 = 3'h5;
  localparam logic [2:0] EQ_CEPT_120 = 3'h6;
  localparam logic [2:0] EQ_UNUSED = 3'h7;
  // ==========================================
  // Signal-loss counts (bit periods)
  localparam int DS1_LOS_ZEROS = 100;
  localparam int CEPT_LOS_ZEROS = 255;
  localparam int DS1_WINDOW = 100;
  localparam int CEPT_WINDOW = 255;
  localparam int DS1_MIN_ONES = 13;
  localparam int CEPT_MIN_ONES = 32;
  localparam int STRICT_MAX_ZRUN = 15;
  localparam int LOOSE_MAX_ZRUN = 99;
  // ==========================================
  // Transmit timing
  localparam int BASE_DELAY = 3;
  localparam int JA_EXTRA_DELAY = 8;
  localparam int CLK_NS = 10;
  localparam int DS1_PW_NS = 350;
  localparam int CEPT_PW_NS = 244;
  localparam int DS1_PW_CYC = DS1_PW_NS / CLK_NS;
  localparam int CEPT_PW_CYC = CEPT_PW_NS / CLK_NS;
  localparam logic [7:0] RST_ZERO = 8'h00;
endpackage : tle_pkg

// ==== design/tle_fifo.sv ====
module tle_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 32
) (
  input wire logic i_mclk, // Clock
  input wire logic i_reset, // Sync reset
  input wire logic i_valid, // Write valid
  output logic o_ready, // Space available
  input wire logic [WIDTH-1:0] i_data, // Write data
  output logic o_valid, // Data available
  input wire logic i_ready, // Read accept
  output logic [WIDTH-1:0] o_data // Read data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_ready = cnt_reg != (AW+1)'(DEPTH);
  assign o_valid = cnt_reg != '0;
  assign o_data = mem_reg[rd_reg];
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_reg[wr_reg] <= i_data;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tle_fifo

// ==== design/tle_quad.sv ====
module tle_quad #(
  parameter int CHANNELS = 4
) (
  input wire logic i_mclk, // 100 MHz clock
  input wire logic i_reset, // Sync reset
  input wire logic [CHANNELS-1:0] i_system_transmit_clock, // Per-channel bit clocks
  input wire logic [CHANNELS-1:0] i_tx_pos_data, // NRZ or positive rail
  input wire logic [CHANNELS-1:0] i_tx_neg_data, // Negative rail
  input wire logic [CHANNELS-1:0] i_rail_select, // Dual-rail select
  input wire logic [CHANNELS-1:0] i_zero_subst, // Substitution enable
  input wire logic [CHANNELS-1:0] i_tx_jitter_atten_select, // Transmit JA
  input wire logic [CHANNELS-1:0] i_eq_code_bit_a, // Eq msb
  input wire logic [CHANNELS-1:0] i_eq_code_bit_b, // Eq mid
  input wire logic [CHANNELS-1:0] i_eq_code_bit_c, // Eq lsb
  input wire logic [CHANNELS-1:0] i_loss_standard_select, // Strict DS1
  input wire logic [CHANNELS-1:0] i_rx_clk_en, // Receive bit strobes
  input wire logic [CHANNELS-1:0] i_rx_mark, // Received marks
  output logic [CHANNELS-1:0] o_line_tip_output, // Tip drive
  output logic [CHANNELS-1:0] o_line_ring_output, // Ring drive
  output logic [CHANNELS-1:0] o_tx_fifo_ready, // Buffer space
  output logic [CHANNELS-1:0] o_cept_mode, // CEPT rate
  output logic [CHANNELS-1:0] o_eq_code_illegal, // Code 111
  output logic [CHANNELS-1:0] o_digital_signal_loss // Loss flags
);
  // ==========================================
  // Independent channels
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    tle_channel u_ch (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_system_transmit_clock(i_system_transmit_clock[c]),
      .i_tx_pos_data(i_tx_pos_data[c]),
      .i_tx_neg_data(i_tx_neg_data[c]),
      .i_rail_select(i_rail_select[c]),
      .i_zero_subst(i_zero_subst[c]),
      .i_tx_jitter_atten_select(i_tx_jitter_atten_select[c]),
      .i_eq_code_bit_a(i_eq_code_bit_a[c]),
      .i_eq_code_bit_b(i_eq_code_bit_b[c]),
      .i_eq_code_bit_c(i_eq_code_bit_c[c]),
      .i_loss_standard_select(i_loss_standard_select[c]),
      .i_rx_clk_en(i_rx_clk_en[c]),
      .i_rx_mark(i_rx_mark[c]),
      .o_line_tip_output(o_line_tip_output[c]),
      .o_line_ring_output(o_line_ring_output[c]),
      .o_tx_fifo_ready(o_tx_fifo_ready[c]),
      .o_cept_mode(o_cept_mode[c]),
      .o_eq_code_illegal(o_eq_code_illegal[c]),
      .o_digital_signal_loss(o_digital_signal_loss[c])
    );
  end
endmodule // tle_quad

// ==== verification/tle_quad_properties.sv ====
module tle_quad_properties #(
  parameter int CHANNELS = 4
) (
  input wire logic i_mclk, // Clock
  input wire logic i_reset, // Reset
  input wire logic [CHANNELS-1:0] i_rail_select, // Dual rail
  input wire logic [CHANNELS-1:0] i_zero_subst, // Substitution
  input wire logic [CHANNELS-1:0] i_eq_code_bit_a, // Eq msb
  input wire logic [CHANNELS-1:0] i_eq_code_bit_b, // Eq mid
  input wire logic [CHANNELS-1:0] i_eq_code_bit_c, // Eq lsb
  input wire logic [CHANNELS-1:0] i_loss_standard_select, // Strict
  input wire logic [CHANNELS-1:0] i_rx_clk_en, // Rx strobe
  input wire logic [CHANNELS-1:0] i_rx_mark, // Rx mark
  input wire logic [CHANNELS-1:0] o_line_tip_output, // Tip
  input wire logic [CHANNELS-1:0] o_line_ring_output, // Ring
  input wire logic [CHANNELS-1:0] o_tx_fifo_ready, // Space
  input wire logic [CHANNELS-1:0] o_cept_mode, // CEPT
  input wire logic [CHANNELS-1:0] o_eq_code_illegal, // Code 111
  input wire logic [CHANNELS-1:0] o_digital_signal_loss // Loss
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Helpers, channel 0 only
  logic [2:0] code;
  logic is_cept, is_ill, loss;
  logic [8:0] zrun;
  logic [5:0] wid;
  logic [1:0] last;
  int lim;
  assign code = {i_eq_code_bit_a[0], i_eq_code_bit_b[0], i_eq_code_bit_c[0]};
  assign is_cept = (code == 3'h5) || (code == 3'h6);
  assign is_ill = (code == 3'h7);
  assign loss = o_digital_signal_loss[0];
  assign lim = o_cept_mode[0] ? 255 : 100;
  always_ff @(posedge i_mclk) begin
    if (i_reset) zrun <= 9'h000;
    else if (i_rx_clk_en[0]) zrun <= i_rx_mark[0] ? 9'h000 : zrun + 9'h001;
  end
  always_ff @(posedge i_mclk) begin
    if (i_reset || !o_line_ring_output[0]) wid <= 6'h00;
    else wid <= wid + 6'h01;
  end
  always_ff @(posedge i_mclk) begin
    if (i_reset) last <= 2'h0;
    else if (o_line_ring_output[0]) last <= 2'h2;
    else if (o_line_tip_output[0]) last <= 2'h1;
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  property p_excl; !(|(o_line_tip_output & o_line_ring_output)); endproperty
  a_excl: assert property (p_excl) else $error("tip and ring high together");
  property p_width;
    $fell(o_line_ring_output[0]) |->
      wid == (o_cept_mode[0] ? tle_pkg::CEPT_PW_CYC : tle_pkg::DS1_PW_CYC);
  endproperty
  a_width: assert property (p_width) else $error("ring pulse width wrong");
  property p_cept; 1 |=> o_cept_mode[0] == $past(is_cept); endproperty
  a_cept: assert property (p_cept) else $error("rate select wrong");
  property p_ill; 1 |=> o_eq_code_illegal[0] == $past(is_ill); endproperty
  a_ill: assert property (p_ill) else $error("unused code flag wrong");
  property p_rst;
    disable iff (1'b0) i_reset |=> (o_line_ring_output | o_line_tip_output
      | o_digital_signal_loss | o_cept_mode) == '0 && &o_tx_fifo_ready;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_set;
    i_rx_clk_en[0] && !i_rx_mark[0] && zrun == lim - 1 |-> ##[1:2] loss;
  endproperty
  a_set: assert property (p_set) else $error("loss flag not raised");
  property p_rise; $rose(loss) |-> zrun >= lim; endproperty
  a_rise: assert property (p_rise) else $error("loss flag raised early");
  property p_fell;
    $fell(loss) |-> zrun <= ((i_loss_standard_select[0] && !o_cept_mode[0]) ? 15 : 99);
  endproperty
  a_fell: assert property (p_fell) else $error("loss cleared despite run");
  property p_ami;
    $rose(o_line_ring_output[0]) && !i_zero_subst[0] && !i_rail_select[0] |-> last != 2'h2;
  endproperty
  a_ami: assert property (p_ami) else $error("marks did not alternate");
  c_rise: cover property ($rose(loss));
  c_fell: cover property ($fell(loss));
  c_cept: cover property ($rose(o_line_ring_output[0]) && o_cept_mode[0]);
endmodule // tle_quad_properties

bind tle_quad tle_quad_properties #(.CHANNELS(CHANNELS)) tle_quad_properties_i (
  .i_mclk, .i_reset, .i_rail_select, .i_zero_subst, .i_eq_code_bit_a,
  .i_eq_code_bit_b, .i_eq_code_bit_c, .i_loss_standard_select, .i_rx_clk_en,
  .i_rx_mark, .o_line_tip_output, .o_line_ring_output, .o_tx_fifo_ready,
  .o_cept_mode, .o_eq_code_illegal, .o_digital_signal_loss
);

// ==== verification/tle_line_model.sv ====
module tle_line_model (
  input wire logic i_mclk, // Clock
  input wire logic i_reset, // Reset
  input wire logic i_tip, // Negative pulse
  input wire logic i_ring, // Positive pulse
  output logic [7:0] o_pos_cnt, // Positive marks
  output logic [7:0] o_neg_cnt, // Negative marks
  output logic [7:0] o_same_cnt // Same-polarity pairs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ring_d, tip_d;
  logic [1:0] last;
  // Count at leading edges so pulse width does not matter
  always @(posedge i_mclk) begin
    ring_d <= i_ring;
    tip_d <= i_tip;
    if (i_reset) begin
      o_pos_cnt <= 8'h00;
      o_neg_cnt <= 8'h00;
      o_same_cnt <= 8'h00;
      last <= 2'h0;
    end else if (i_ring && !ring_d) begin
      o_pos_cnt <= o_pos_cnt + 8'h01;
      if (last == 2'h2) o_same_cnt <= o_same_cnt + 8'h01;
      last <= 2'h2;
    end else if (i_tip && !tip_d) begin
      o_neg_cnt <= o_neg_cnt + 8'h01;
      if (last == 2'h1) o_same_cnt <= o_same_cnt + 8'h01;
      last <= 2'h1;
    end
  end
endmodule // tle_line_model

// ==== verification/tle_quad_tb_top.sv ====
module tle_quad_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk, i_reset;
  logic [3:0] i_system_transmit_clock, i_tx_pos_data, i_tx_neg_data, i_rail_select;
  logic [3:0] i_zero_subst, i_tx_jitter_atten_select, i_eq_code_bit_a, i_eq_code_bit_b;
  logic [3:0] i_eq_code_bit_c, i_loss_standard_select, i_rx_clk_en, i_rx_mark;
  logic [3:0] o_line_tip_output, o_line_ring_output, o_tx_fifo_ready;
  logic [3:0] o_cept_mode, o_eq_code_illegal, o_digital_signal_loss;
  logic [7:0] pos_cnt, neg_cnt, same_cnt;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  tle_quad #(.CHANNELS(4)) tle_quad_i (.i_mclk, .i_reset, .i_system_transmit_clock,
    .i_tx_pos_data, .i_tx_neg_data, .i_rail_select, .i_zero_subst,
    .i_tx_jitter_atten_select, .i_eq_code_bit_a, .i_eq_code_bit_b, .i_eq_code_bit_c,
    .i_loss_standard_select, .i_rx_clk_en, .i_rx_mark, .o_line_tip_output,
    .o_line_ring_output, .o_tx_fifo_ready, .o_cept_mode, .o_eq_code_illegal,
    .o_digital_signal_loss);
  tle_line_model tle_line_model_i (.i_mclk, .i_reset, .i_tip(o_line_tip_output[0]),
    .i_ring(o_line_ring_output[0]), .o_pos_cnt(pos_cnt), .o_neg_cnt(neg_cnt),
    .o_same_cnt(same_cnt));
  // ==========================================
  // Clock, timeout and shared tasks
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      $display("timeout after %0d cycles", cyc);
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic do_reset();
    @(negedge i_mclk) i_reset = 1'b1;
    repeat (6) @(negedge i_mclk);
    i_reset = 1'b0;
  endtask
  task automatic set_mode(logic [2:0] c, logic zs, logic rail, logic strict);
    @(negedge i_mclk);
    {i_eq_code_bit_a[0], i_eq_code_bit_b[0], i_eq_code_bit_c[0]} = c;
    {i_eq_code_bit_a[1], i_eq_code_bit_b[1], i_eq_code_bit_c[1]} = ~c;
    i_zero_subst[0] = zs;
    i_rail_select[0] = rail;
    i_loss_standard_select[0] = strict;
  endtask
  // Framer bit: data settles a half period before the rising bit edge
  task automatic tx_bit(logic p, logic n);
    @(negedge i_mclk);
    i_tx_pos_data[0] = p;
    i_tx_neg_data[0] = n;
    repeat (40) @(negedge i_mclk);
    i_system_transmit_clock[0] = 1'b1;
    repeat (40) @(negedge i_mclk);
    i_system_transmit_clock[0] = 1'b0;
  endtask
  task automatic rx_run(int n, int per, int k);
    for (int i = 0; i < n; i++) begin
      @(negedge i_mclk);
      i_rx_clk_en[0] = 1'b1;
      i_rx_mark[0] = (i % per) < k;
      @(negedge i_mclk);
      i_rx_clk_en[0] = 1'b0;
      i_rx_mark[0] = ~i_rx_mark[0];
      repeat (2) @(negedge i_mclk);
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_eq();
    for (int c = 0; c < 8; c++) begin
      set_mode(c[2:0], 1'b0, 1'b0, 1'b0);
      repeat (3) @(negedge i_mclk);
      chk("cept", {6'h00, c == 2 || c == 1, c == 5 || c == 6}, {6'h00, o_cept_mode[1:0]});
      chk("illegal", {6'h00, c == 0, c == 7}, {6'h00, o_eq_code_illegal[1:0]});
    end
    $display("t_eq done");
  endtask
  task automatic t_ami();
    do_reset();
    set_mode(3'h4, 1'b0, 1'b0, 1'b0);
    chk("reset", 8'h0F, {o_line_ring_output | o_line_tip_output | o_digital_signal_loss,
      o_tx_fifo_ready});
    tx_bit(1'b1, 1'b0);
    tx_bit(1'b0, 1'b0);
    chk("early", 8'h00, pos_cnt + neg_cnt);
    repeat (3) tx_bit(1'b1, 1'b0);
    repeat (12) tx_bit(1'b0, 1'b0);
    chk("ami", 8'h22, {pos_cnt[3:0], neg_cnt[3:0]});
    chk("ami_same", 8'h00, same_cnt);
    $display("t_ami done");
  endtask
  task automatic t_subst(logic cept);
    do_reset();
    set_mode(cept ? 3'h5 : 3'h0, 1'b1, 1'b0, 1'b0);
    tx_bit(1'b1, 1'b0);
    repeat (cept ? 4 : 8) tx_bit(1'b0, 1'b0);
    tx_bit(1'b1, 1'b0);
    // Trailing zeros are substituted too; only the first 14 or 18 bits reach the line
    repeat (18) tx_bit(1'b0, 1'b0);
    chk("subst_marks", cept ? 8'h06 : 8'h0A, pos_cnt + neg_cnt);
    chk("subst_viol", cept ? 8'h03 : 8'h04, same_cnt);
    $display("t_subst done");
  endtask
  task automatic t_dual();
    do_reset();
    set_mode(3'h0, 1'b1, 1'b1, 1'b0);
    repeat (2) tx_bit(1'b1, 1'b0);
    tx_bit(1'b0, 1'b1);
    repeat (20) tx_bit(1'b0, 1'b0);
    chk("dual", 8'h21, {pos_cnt[3:0], neg_cnt[3:0]});
    chk("dual_same", 8'h01, same_cnt);
    $display("t_dual done");
  endtask
  task automatic t_ja();
    do_reset();
    set_mode(3'h0, 1'b0, 1'b0, 1'b0);
    i_tx_jitter_atten_select[0] = 1'b1;
    tx_bit(1'b1, 1'b0);
    repeat (11) tx_bit(1'b0, 1'b0);
    chk("ja_early", 8'h00, pos_cnt + neg_cnt);
    tx_bit(1'b0, 1'b0);
    chk("ja_late", 8'h01, pos_cnt + neg_cnt);
    i_tx_jitter_atten_select[0] = 1'b0;
    $display("t_ja done");
  endtask
  task automatic t_los(logic cept, logic strict, int per, int k, logic exp);
    int n;
    n = cept ? 255 : 100;
    do_reset();
    set_mode(cept ? 3'h5 : 3'h0, 1'b0, 1'b0, strict);
    rx_run(n - 1, 1, 0);
    chk("los_short", 8'h00, {7'h00, o_digital_signal_loss[0]});
    rx_run(1, 1, 0);
    chk("los_set", 8'h01, {7'h00, o_digital_signal_loss[0]});
    rx_run(3 * n, per, k);
    chk("los_clear", {7'h00, exp}, {7'h00, o_digital_signal_loss[0]});
    $display("t_los done");
  endtask
  initial begin
    i_reset = 1'b1;
    {i_system_transmit_clock, i_tx_pos_data, i_tx_neg_data, i_rail_select} = '0;
    {i_zero_subst, i_tx_jitter_atten_select, i_eq_code_bit_a, i_eq_code_bit_b} = '0;
    {i_eq_code_bit_c, i_loss_standard_select, i_rx_clk_en, i_rx_mark} = '0;
    do_reset();
    t_eq();
    t_ami();
    t_subst(1'b0);
    t_subst(1'b1);
    t_dual();
    t_ja();
    t_los(1'b0, 1'b0, 7, 1, 1'b0);
    t_los(1'b1, 1'b1, 7, 1, 1'b0);
    t_los(1'b0, 1'b1, 20, 4, 1'b1);
    t_los(1'b0, 1'b0, 20, 4, 1'b0);
    finish_test();
  end
endmodule // tle_quad_tb_top
